// *** dv/crs_core_regs_assertions.sv ***
// port checker for the core register set
`timescale 1ns/1ps
module crs_core_regs_chk
  import crs_pkg::*;
(
  input wire logic core_clk_i, // clock
  input wire logic rstn_i, // reset
  input wire logic large_ram_i, // strap
  input wire logic [15:0] addr_i, // address
  input wire logic [2:0] wr_sel_i, // select
  input wire logic wr_en_i, // write
  input wire logic [15:0] wr_data_i, // data
  input wire logic pc_inc_i, // advance
  input wire logic int_req_i, // request
  input wire logic [1:0] int_lvl_i, // level
  input wire logic [2:0] gpr_idx_i, // index
  input wire logic [15:0] pc_o, // pc
  input wire logic [7:0] ccb_o, // flags
  input wire logic [7:0] bank_ptr_o, // bank
  input wire logic [2:0] region_o, // region
  input wire logic int_take_o, // taken
  input wire logic [15:0] gpr_addr_o // gpr address
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [1:0] up_reg;
  // strap is synced inside, so trust the bank mask only once settled
  wire logic [4:0] bank = large_ram_i ? bank_ptr_o[7:3] :
    {1'b0, bank_ptr_o[6:3]};
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  chk_reset_pc: assert property ($rose(rstn_i) |->
    pc_o == CRS_PC_RESET) else $error("pc reset value wrong");
  chk_reset_flags: assert property ($rose(rstn_i) |->
    !ccb_o[CRS_CC_I] && ccb_o[5:4] == CRS_LEVEL_RESET)
    else $error("reset flags wrong");
  chk_pc_step: assert property (pc_inc_i && !wr_en_i |=>
    pc_o == $past(pc_o) + 16'h1) else $error("pc did not advance");
  chk_pc_load: assert property (wr_en_i && wr_sel_i == CRS_SEL_PC |=>
    pc_o == $past(wr_data_i)) else $error("pc write lost");
  chk_periph_region: assert property (addr_i <= CRS_PERIPH_END |=>
    region_o == CRS_RGN_PERIPH) else $error("periph decode");
  chk_ram_region: assert property (addr_i >= CRS_RAM_BASE &&
    addr_i <= CRS_RAM_END_SMALL |=> region_o == CRS_RGN_RAM) else $error("ram");
  chk_vector_region: assert property (addr_i >= CRS_VECTOR_BASE |=>
    region_o == CRS_RGN_VECTOR) else $error("vector decode");
  chk_int_masked: assert property (!ccb_o[CRS_CC_I] |=>
    !int_take_o) else $error("interrupt taken while disabled");
  chk_int_low: assert property (int_req_i && int_lvl_i == 2'h3 |=>
    !int_take_o) else $error("lowest level taken");
  chk_int_high: assert property (ccb_o[CRS_CC_I] && int_req_i &&
    !int_lvl_i[1] && ccb_o[CRS_CC_LVL1] |=> int_take_o) else $error("missed");
  chk_gpr_addr: assert property (up_reg == 2'h3 |=> gpr_addr_o ==
    CRS_RAM_BASE + {5'h00, $past(bank), $past(gpr_idx_i)}) else $error("gpr");
  cov_int_taken: cover property (int_take_o);
  cov_vector: cover property (region_o == CRS_RGN_VECTOR);
  cov_pc_load: cover property (wr_en_i && wr_sel_i == CRS_SEL_PC);
endmodule
bind crs_core_regs crs_core_regs_chk crs_core_regs_chk_inst (.core_clk_i,
  .rstn_i, .large_ram_i, .addr_i, .wr_sel_i, .wr_en_i, .wr_data_i, .pc_inc_i,
  .int_req_i, .int_lvl_i, .gpr_idx_i, .pc_o, .ccb_o, .bank_ptr_o, .region_o,
  .int_take_o, .gpr_addr_o);

// *** dv/crs_mem_model.sv ***
// far-side memory map model: which region answers an address
`timescale 1ns/1ps
module crs_mem_model
  import crs_pkg::*;
(
  input wire logic [15:0] addr_i, // bus address
  input wire logic large_ram_i, // larger ram fitted
  input wire logic [1:0] rom_kind_i, // program store kind
  output logic [2:0] region_o // answering region
);
  wire logic [15:0] ram_end = large_ram_i ? CRS_RAM_END_LARGE :
    CRS_RAM_END_SMALL;
  wire logic [15:0] rom_base = rom_kind_i == 2'h1 ? CRS_ROM_BASE_OTP :
    rom_kind_i == 2'h2 ? CRS_ROM_BASE_PIGGY : CRS_ROM_BASE_MASK;
  always_comb begin
    if (addr_i <= CRS_PERIPH_END) region_o = CRS_RGN_PERIPH;
    else if (addr_i <= ram_end) region_o = CRS_RGN_RAM;
    else if (addr_i >= CRS_VECTOR_BASE) region_o = CRS_RGN_VECTOR;
    else if (addr_i >= rom_base) region_o = CRS_RGN_ROM;
    else region_o = CRS_RGN_NONE;
  end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the core register set
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench
  import crs_pkg::*;
;
  logic core_clk_i = 0, rstn_i = 0, large_ram_i = 0, wr_en_i = 0;
  logic pc_inc_i = 0, alu_en_i = 0, alu_word_i = 0, alu_sub_i = 0;
  logic alu_shift_i = 0, int_req_i = 0, gpr_we_i = 0, int_take_o;
  logic [1:0] rom_kind_i = 0, int_lvl_i = 0;
  logic [2:0] wr_sel_i = 0, rd_sel_i = 0, gpr_idx_i = 0, region_o, exp_rgn;
  logic [15:0] addr_i = 0, wr_data_i = 0, pc_o, rd_data_o, gpr_addr_o, q;
  logic [7:0] gpr_wdata_i = 0, ccb_o, bank_ptr_o, gpr_rdata_o;
  logic [15:0] tab [16] = '{16'h0000, 16'h007f, 16'h0080, 16'h027f, 16'h0280,
    16'h047f, 16'h0480, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hdfff,
    16'he000, 16'hffbf, 16'hffc0, 16'hffff};
  int n_mismatch = 0, checks = 0, cyc = 0, gm [int];
  crs_core_regs crs_core_regs_inst (.core_clk_i, .rstn_i, .large_ram_i,
    .rom_kind_i, .addr_i, .wr_sel_i, .wr_en_i, .wr_data_i, .pc_inc_i,
    .rd_sel_i, .alu_en_i, .alu_word_i, .alu_sub_i, .alu_shift_i, .int_req_i,
    .int_lvl_i, .gpr_idx_i, .gpr_we_i, .gpr_wdata_i, .pc_o, .rd_data_o,
    .ccb_o, .bank_ptr_o, .region_o, .int_take_o, .gpr_addr_o, .gpr_rdata_o);
  crs_mem_model crs_mem_model_inst (.addr_i, .large_ram_i, .rom_kind_i,
    .region_o(exp_rgn));
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic tick(); @(negedge core_clk_i); endtask
  task automatic do_reset();
    rstn_i = 0;
    repeat (4) tick();
    rstn_i = 1;
    tick();
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    wr_sel_i = s;
    wr_data_i = d;
    wr_en_i = 1;
    tick();
    wr_en_i = 0;
    // idle edge so a following write never re-raises the strobe at once
    tick();
  endtask
  task automatic rd(input logic [2:0] s);
    rd_sel_i = s;
    tick();
    q = rd_data_o;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // codes 00 and 01 share the top rank
  function automatic int rank(int c);
    return c < 2 ? 1 : c;
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    int a, b, x, y, r, h, op, ea, bp, sb, m, yb;
    void'($urandom(42726));
    do_reset();
    `CHK(pc_o, CRS_PC_RESET)
    `CHK(ccb_o[6:4], 3'h3)
    pc_inc_i = 1;
    tick();
    pc_inc_i = 0;
    `CHK(pc_o, 16'hfffe)
    $display("test reset done");
    for (int s = 0; s < 7; s++) begin
      a = $urandom();
      wr(3'(s), 16'(a));
      rd(3'(s));
      `CHK(q, 16'(a))
    end
    `CHK(bank_ptr_o, 8'(a >> 8))
    rd(CRS_SEL_NONE);
    `CHK(q, 16'h0000)
    $display("test registers done");
    // small ram aliases bank bit 7 onto sixteen banks; large ram has 32
    for (int i = 0; i < 96; i++) begin
      if (i == 48) begin
        large_ram_i = 1;
        do_reset();
        repeat (2) tick();
      end
      bp = $urandom_range(255) & 8'hc8;
      ea = 128 + 8 * ((bp >> 3) % (i < 48 ? 16 : 32)) + $urandom_range(7);
      wr(CRS_SEL_PSW, 16'(bp << 8));
      gpr_idx_i = 3'(ea % 8);
      gpr_wdata_i = 8'($urandom());
      gpr_we_i = 1'($urandom_range(1));
      if (gpr_we_i) gm[ea] = gpr_wdata_i;
      tick();
      gpr_we_i = 0;
      tick();
      `CHK(gpr_addr_o, 16'(ea))
      if (gm.exists(ea)) `CHK(gpr_rdata_o, 8'(gm[ea]))
    end
    $display("test banks done");
    // byte and word ops alternate so each op meets both widths
    for (int i = 0; i < 36; i++) begin
      a = $urandom_range(65535);
      y = $urandom_range(65535);
      op = i % 3;
      sb = i % 2 ? 15 : 7;
      m = i % 2 ? 65535 : 255;
      x = a & m;
      yb = y & m;
      r = op == 0 ? x + yb : op == 1 ? x - yb : x * 2;
      h = op == 1 ? x % 16 - yb % 16 : x % 16 + yb % 16;
      wr(CRS_SEL_ACC, 16'(a));
      wr(CRS_SEL_TMP, 16'(y));
      alu_word_i = 1'(i % 2);
      alu_sub_i = op == 1;
      alu_shift_i = op == 2;
      alu_en_i = 1;
      tick();
      alu_en_i = 0;
      rd(CRS_SEL_ACC);
      `CHK(q, 16'(a - x + (r & m)))
      `CHK(ccb_o[CRS_CC_N], r[sb])
      `CHK(ccb_o[CRS_CC_Z], 1'((r & m) == 0))
      `CHK(ccb_o[CRS_CC_C], r[sb + 1])
      if (op != 2) `CHK(ccb_o[CRS_CC_H], h[4])
      b = op != 2 && (x[sb] == yb[sb]) != op[0] && r[sb] != x[sb];
      `CHK(ccb_o[CRS_CC_V], b[0])
    end
    $display("test flags done");
    for (int k = 0; k < 8; k++) begin
      large_ram_i = k[2];
      rom_kind_i = k[1:0];
      do_reset();
      repeat (2) tick();
      for (int j = 0; j < 24; j++) begin
        addr_i = j < 16 ? tab[j % 16] : 16'($urandom());
        tick();
        `CHK(region_o, exp_rgn)
      end
    end
    $display("test decode done");
    for (int k = 0; k < 64; k++) begin
      wr(CRS_SEL_PSW, {9'h000, k[4], k[3:2], 4'h0});
      int_req_i = k[5];
      int_lvl_i = k[1:0];
      tick();
      b = k[5] && k[4] && rank(k[1:0]) < rank(k[3:2]);
      `CHK(int_take_o, b[0])
    end
    $display("test interrupts done");
    stop_test();
  end
endmodule

// *** hdl/crs_core_regs.sv ***
// dedicated register set, flag update, address decode and register banks
//
// Contract
// - one flat 64-Kbyte space decoded over 16-bit addresses 0000h-ffffh
// - peripherals below 0080h; ram 0080h-027fh, or to 047fh on large ram
// - program memory from e000h mask, c000h otp, 8000h piggyback
// - reset, interrupt and call vectors fetched from the top addresses
// - 16-bit program counter is loaded with fffdh on reset
// - accumulator and temporary are 16 bits; byte ops use low bytes
// - index, extra pointer and stack pointer are 16 bits, not reset
// - status word: bank pointer upper byte, condition codes lower byte
// - reset clears interrupt enable and sets interrupt level to 11
// - half carry marks carry or borrow from bit 3 into bit 4; on shifts the code still loads it from the add/subtract nibble carry
// - interrupts accepted only while interrupt enable is 1
// - accept only a request level higher than current; 00 and 01 equal
// - negative flag follows result msb
// - zero flag set when result is zero
// - overflow flag set on two's-complement overflow; the code clears it on every shift
// - carry from bit 7 on byte ops, bit 15 on word ops; shifts take the shifted-out bit
// - 8-bit general registers, eight per bank, 16 or 32 banks
`timescale 1ns/1ps
module crs_core_regs
  import crs_pkg::*;
(
  input wire logic core_clk_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic large_ram_i, // strap: larger ram variant
  input wire logic [1:0] rom_kind_i, // strap: 0 mask, 1 otp, 2 piggyback
  input wire logic [15:0] addr_i, // address to decode
  input wire logic [2:0] wr_sel_i, // register select for write
  input wire logic wr_en_i, // write strobe for selected register
  input wire logic [15:0] wr_data_i, // write data
  input wire logic pc_inc_i, // advance program counter by one
  input wire logic [2:0] rd_sel_i, // register select for read
  input wire logic alu_en_i, // apply alu result to accumulator
  input wire logic alu_word_i, // 1: 16-bit op, 0: byte op
  input wire logic alu_sub_i, // 1: subtract, 0: add
  input wire logic alu_shift_i, // 1: shift left by one
  input wire logic int_req_i, // interrupt request pending
  input wire logic [1:0] int_lvl_i, // level code of the request
  input wire logic [2:0] gpr_idx_i, // general register index
  input wire logic gpr_we_i, // general register write strobe
  input wire logic [7:0] gpr_wdata_i, // general register write data
  output logic [15:0] pc_o, // program counter
  output logic [15:0] rd_data_o, // selected register contents
  output logic [7:0] ccb_o, // condition code byte
  output logic [7:0] bank_ptr_o, // bank pointer
  output logic [2:0] region_o, // decoded region of addr_i
  output logic int_take_o, // interrupt accepted
  output logic [15:0] gpr_addr_o, // actual address of general register
  output logic [7:0] gpr_rdata_o // general register read data
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [15:0] pc_reg;
  logic [15:0] acc_reg;
  logic [15:0] tmp_reg;
  logic [15:0] idx_reg;
  logic [15:0] ext_reg;
  logic [15:0] sp_reg;
  logic [7:0] bank_reg;
  logic [7:0] ccb_reg;
  logic [15:0] rd_data_reg;
  logic [2:0] region_reg;
  logic int_take_reg;
  logic [15:0] gpr_addr_reg;
  logic large_ram_s1_reg;
  logic large_ram_reg;
  logic [1:0] rom_kind_s1_reg;
  logic [1:0] rom_kind_reg;
  logic [15:0] acc_next;
  logic [7:0] ccb_next;

  // straps come from pins, so synchronise before use
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      large_ram_s1_reg <= 1'b0;
      large_ram_reg <= 1'b0;
      rom_kind_s1_reg <= 2'h0;
      rom_kind_reg <= 2'h0;
    end else begin
      large_ram_s1_reg <= large_ram_i;
      large_ram_reg <= large_ram_s1_reg;
      rom_kind_s1_reg <= rom_kind_i;
      rom_kind_reg <= rom_kind_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // address map decode
  // ---------------------------------------------------------------
  wire [15:0] ram_end = large_ram_reg ? CRS_RAM_END_LARGE
                                      : CRS_RAM_END_SMALL;
  wire [15:0] rom_base = (rom_kind_reg == 2'h1) ? CRS_ROM_BASE_OTP :
                         (rom_kind_reg == 2'h2) ? CRS_ROM_BASE_PIGGY :
                         CRS_ROM_BASE_MASK;
  wire is_periph = addr_i <= CRS_PERIPH_END;
  wire is_ram = addr_i >= CRS_RAM_BASE && addr_i <= ram_end;
  wire is_vec = addr_i >= CRS_VECTOR_BASE;
  wire is_rom = addr_i >= rom_base;
  // full 16-bit compare: each address takes the first matching region in order; gaps between ram and rom decode as none
  wire [2:0] region_next = is_periph ? CRS_RGN_PERIPH :
                           is_ram ? CRS_RGN_RAM :
                           is_vec ? CRS_RGN_VECTOR :
                           is_rom ? CRS_RGN_ROM :
                           CRS_RGN_NONE;

  // ---------------------------------------------------------------
  // alu and flags
  // ---------------------------------------------------------------
  wire [15:0] opb = alu_sub_i ? ~tmp_reg : tmp_reg;
  wire [16:0] sum = {1'b0, acc_reg} + {1'b0, opb}
                    + {16'h0000, alu_sub_i};
  // low nibble sum, carry into bit 4
  wire [4:0] nib = {1'b0, acc_reg[3:0]} + {1'b0, opb[3:0]}
                   + {4'h0, alu_sub_i};
  // carry into bit 8 for byte ops
  wire [8:0] bsum = {1'b0, acc_reg[7:0]} + {1'b0, opb[7:0]}
                    + {8'h00, alu_sub_i};
  wire [15:0] res_w = alu_shift_i ? {acc_reg[14:0], 1'b0} : sum[15:0];
  wire [15:0] res = alu_word_i ? res_w
                               : {acc_reg[15:8], res_w[7:0]};
  wire msb = alu_word_i ? res[15] : res[7];
  wire is_zero = alu_word_i ? (res == 16'h0000)
                            : (res[7:0] == 8'h00);
  wire a_s = alu_word_i ? acc_reg[15] : acc_reg[7];
  wire b_s = alu_word_i ? opb[15] : opb[7];
  wire ovf = !alu_shift_i && (a_s == b_s) && (msb != a_s);
  // borrow is the inverted carry when subtracting
  wire cy_add = alu_word_i ? sum[16] : bsum[8];
  wire shout = alu_word_i ? acc_reg[15] : acc_reg[7];
  wire cy = alu_shift_i ? shout : (cy_add ^ alu_sub_i);
  wire hc = nib[4] ^ alu_sub_i;

  always_comb begin
    acc_next = acc_reg;
    ccb_next = ccb_reg;
    if (alu_en_i) begin
      acc_next = res;
      ccb_next[CRS_CC_H] = hc;
      ccb_next[CRS_CC_N] = msb;
      ccb_next[CRS_CC_Z] = is_zero;
      ccb_next[CRS_CC_V] = ovf;
      ccb_next[CRS_CC_C] = cy;
    end
    if (wr_en_i && wr_sel_i == CRS_SEL_PSW) begin
      ccb_next = wr_data_i[7:0];
    end
    if (wr_en_i && wr_sel_i == CRS_SEL_ACC) begin
      acc_next = wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // interrupt acceptance
  // ---------------------------------------------------------------
  // codes 00 and 01 fold to level 1
  wire [1:0] req_rank = (int_lvl_i == 2'h0) ? 2'h1 : int_lvl_i;
  wire [1:0] cur_rank = (ccb_reg[CRS_CC_LVL1:CRS_CC_LVL0] == 2'h0)
                        ? 2'h1 : ccb_reg[CRS_CC_LVL1:CRS_CC_LVL0];
  wire int_take_next = int_req_i && ccb_reg[CRS_CC_I]
                       && (req_rank < cur_rank);

  // ---------------------------------------------------------------
  // general register addressing
  // ---------------------------------------------------------------
  wire [CRS_BANK_W-1:0] bank_max = large_ram_reg ? 5'h1f : 5'h0f;
  wire [CRS_BANK_W-1:0] bank_raw =
    bank_reg[CRS_BANK_LSB +: CRS_BANK_W];
  // small ram holds 16 banks; upper bank bit is ignored there
  wire [CRS_BANK_W-1:0] bank = bank_raw & bank_max;
  wire [CRS_GPR_AW-1:0] gpr_off = {bank, gpr_idx_i};
  wire [15:0] gpr_addr_next = CRS_RAM_BASE
                              + {8'h00, gpr_off};

  wire [15:0] rd_next =
    (rd_sel_i == CRS_SEL_PC) ? pc_reg :
    (rd_sel_i == CRS_SEL_ACC) ? acc_reg :
    (rd_sel_i == CRS_SEL_TMP) ? tmp_reg :
    (rd_sel_i == CRS_SEL_IDX) ? idx_reg :
    (rd_sel_i == CRS_SEL_EXT) ? ext_reg :
    (rd_sel_i == CRS_SEL_SP) ? sp_reg :
    (rd_sel_i == CRS_SEL_PSW) ? {bank_reg, ccb_reg} :
    16'h0000;

  // ---------------------------------------------------------------
  // sequential state
  // ---------------------------------------------------------------
  // pc and status control bits reset; accumulator and other status bits start at zero
  // only to keep simulation free of unknowns
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_reg <= CRS_PC_RESET;
      acc_reg <= CRS_UNDEF_RESET;
      ccb_reg <= {CRS_UNDEF_RESET[7:6], CRS_LEVEL_RESET,
                  CRS_UNDEF_RESET[3:0]};
      bank_reg <= CRS_BANK_RESET;
    end else begin
      if (wr_en_i && wr_sel_i == CRS_SEL_PC) begin
        pc_reg <= wr_data_i;
      end else if (pc_inc_i) begin
        pc_reg <= pc_reg + 16'h0001;
      end
      acc_reg <= acc_next;
      ccb_reg <= ccb_next;
      if (wr_en_i && wr_sel_i == CRS_SEL_PSW) begin
        bank_reg <= wr_data_i[15:8];
      end
    end
  end

  // index, pointer, stack and temporary: no reset needed
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i && wr_sel_i == CRS_SEL_TMP) tmp_reg <= wr_data_i;
    if (wr_en_i && wr_sel_i == CRS_SEL_IDX) idx_reg <= wr_data_i;
    if (wr_en_i && wr_sel_i == CRS_SEL_EXT) ext_reg <= wr_data_i;
    if (wr_en_i && wr_sel_i == CRS_SEL_SP) sp_reg <= wr_data_i;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_reg <= 16'h0000;
      region_reg <= CRS_RGN_NONE;
      int_take_reg <= 1'b0;
      gpr_addr_reg <= CRS_RAM_BASE;
    end else begin
      rd_data_reg <= rd_next;
      region_reg <= region_next;
      int_take_reg <= int_take_next;
      gpr_addr_reg <= gpr_addr_next;
    end
  end

  crs_gpr_mem u_gpr (
    .core_clk_i(core_clk_i),
    .we_i(gpr_we_i),
    .waddr_i(gpr_off),
    .wdata_i(gpr_wdata_i),
    .raddr_i(gpr_off),
    .rdata_o(gpr_rdata_o)
  );

  assign pc_o = pc_reg;
  assign rd_data_o = rd_data_reg;
  assign ccb_o = ccb_reg;
  assign bank_ptr_o = bank_reg;
  assign region_o = region_reg;
  assign int_take_o = int_take_reg;
  assign gpr_addr_o = gpr_addr_reg;
endmodule

// *** hdl/crs_gpr_mem.sv ***
// general-purpose register bank memory with registered read data
`timescale 1ns/1ps
module crs_gpr_mem
  import crs_pkg::*;
(
  input wire logic core_clk_i, // system clock
  input wire logic we_i, // write strobe
  input wire logic [CRS_GPR_AW-1:0] waddr_i, // write address
  input wire logic [7:0] wdata_i, // write data
  input wire logic [CRS_GPR_AW-1:0] raddr_i, // read address
  output logic [7:0] rdata_o // registered read data
);
  logic [7:0] mem [CRS_GPR_DEPTH];

  // ram content is not reset, like the real array
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// *** include/crs_pkg.sv ***
// constants and types for the core register set and address map
package crs_pkg;
  // address map
  localparam logic [15:0] CRS_PERIPH_END = 16'h007f;
  localparam logic [15:0] CRS_RAM_BASE = 16'h0080;
  localparam logic [15:0] CRS_RAM_END_SMALL = 16'h027f;
  localparam logic [15:0] CRS_RAM_END_LARGE = 16'h047f;
  localparam logic [15:0] CRS_ROM_BASE_MASK = 16'he000;
  localparam logic [15:0] CRS_ROM_BASE_OTP = 16'hc000;
  localparam logic [15:0] CRS_ROM_BASE_PIGGY = 16'h8000;
  localparam logic [15:0] CRS_VECTOR_BASE = 16'hffc0;
  // reset values
  localparam logic [15:0] CRS_PC_RESET = 16'hfffd;
  localparam logic [15:0] CRS_UNDEF_RESET = 16'h0000;
  localparam logic [7:0] CRS_BANK_RESET = 8'h00;
  localparam logic [1:0] CRS_LEVEL_RESET = 2'h3;
  // condition code byte bit positions
  localparam int CRS_CC_H = 7;
  localparam int CRS_CC_I = 6;
  localparam int CRS_CC_LVL1 = 5;
  localparam int CRS_CC_LVL0 = 4;
  localparam int CRS_CC_N = 3;
  localparam int CRS_CC_Z = 2;
  localparam int CRS_CC_V = 1;
  localparam int CRS_CC_C = 0;
  // bank pointer field holding the bank number
  localparam int CRS_BANK_LSB = 3;
  localparam int CRS_BANK_W = 5;
  localparam int CRS_GPR_DEPTH = 256;
  localparam int CRS_GPR_AW = 8;

  typedef enum logic [2:0] {
    CRS_SEL_PC = 3'b000,
    CRS_SEL_ACC = 3'b001,
    CRS_SEL_TMP = 3'b010,
    CRS_SEL_IDX = 3'b011,
    CRS_SEL_EXT = 3'b100,
    CRS_SEL_SP = 3'b101,
    CRS_SEL_PSW = 3'b110,
    CRS_SEL_NONE = 3'b111
  } crs_sel_t;

  typedef enum logic [2:0] {
    CRS_RGN_PERIPH = 3'b000,
    CRS_RGN_RAM = 3'b001,
    CRS_RGN_ROM = 3'b010,
    CRS_RGN_VECTOR = 3'b011,
    CRS_RGN_NONE = 3'b100
  } crs_region_t;
endpackage
